/* csst_pkg.sv */
// How it works
// - fuse codes 0001..0100 select internal RC at 1, 2, 4, 8 MHz
// - shipped fuse defaults are 1 MHz RC and the slowly-rising-power startup code
// - RC startup codes give 6 cycles; reset delay none, 4.1 ms, 65 ms; 11 reserved
// - external clock input is used only for select code 0000
// - external clock uses the same startup and reset delay settings as RC
// - every reset copies the 1 MHz calibration byte into the trim register
// - trim register is software writable; zero slowest, all-ones fastest
// - guaranteed range 50-100% at 0x00, 75-150% at 0x7F, 100-200% at 0xFF
// - watchdog oscillator still times watchdog and reset time-out under RC clock
// - with RC selected the two crystal pins are freed for I/O or timer
package csst_pkg;

  // clock source select codes
  localparam logic [3:0] SRC_EXT          = 4'h0;
  localparam logic [3:0] SRC_RC1          = 4'h1;
  localparam logic [3:0] SRC_RC2          = 4'h2;
  localparam logic [3:0] SRC_RC4          = 4'h3;
  localparam logic [3:0] SRC_RC8          = 4'h4;
  localparam logic [3:0] SRC_FUSE_DEFAULT = SRC_RC1;

  // startup time codes
  localparam logic [1:0] SUT_NONE         = 2'h0;
  localparam logic [1:0] SUT_SHORT        = 2'h1;
  localparam logic [1:0] SUT_LONG         = 2'h2;
  localparam logic [1:0] SUT_RESERVED     = 2'h3;
  localparam logic [1:0] SUT_FUSE_DEFAULT = SUT_LONG;

  // rc range encodings
  localparam logic [1:0] RC_RANGE_1MHZ = 2'h0;
  localparam logic [1:0] RC_RANGE_2MHZ = 2'h1;
  localparam logic [1:0] RC_RANGE_4MHZ = 2'h2;
  localparam logic [1:0] RC_RANGE_8MHZ = 2'h3;

  // timing
  localparam int         STARTUP_W            = 3;
  localparam logic [2:0] STARTUP_CK           = 3'h6;
  localparam real        CLK_PERIOD_NS        = 10.0;
  localparam real        RESET_DELAY_SHORT_MS = 4.1;
  localparam real        RESET_DELAY_LONG_MS  = 65.0;
  localparam int         DELAY_W              = 24;
  localparam int         DELAY_SHORT_CYC      = int'($ceil(RESET_DELAY_SHORT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int         DELAY_LONG_CYC       = int'($ceil(RESET_DELAY_LONG_MS * 1.0e6 / CLK_PERIOD_NS));

  // trim
  localparam logic [7:0]  TRIM_RESET   = 8'h00;
  localparam logic [7:0]  TRIM_MID     = 8'h7f;
  localparam logic [15:0] PCT_LOW_MIN  = 16'h0032;
  localparam logic [15:0] PCT_MID_MIN  = 16'h004b;
  localparam logic [15:0] PCT_STEP     = 16'h0019;
  localparam logic [15:0] TRIM_LO_SPAN = 16'h007f;
  localparam logic [15:0] TRIM_HI_SPAN = 16'h0080;

  // register map
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_TRIM   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CALIB  = 12'h008;
  localparam logic [11:0] ADDR_RANGE  = 12'h00c;

  // status fields
  localparam int ST_SRC_LSB    = 0;
  localparam int ST_SUT_LSB    = 4;
  localparam int ST_STATE_LSB  = 8;
  localparam int ST_INTRST_BIT = 10;
  localparam int ST_SYSCLK_BIT = 11;
  localparam int ST_BADSRC_BIT = 12;
  localparam int ST_BADSUT_BIT = 13;
  localparam int RANGE_MAX_LSB = 16;

  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_DELAY   = 2'b01,
    ST_RUN     = 2'b11,
    ST_SLEEP   = 2'b10
  } csst_state_type;

  typedef struct packed {
    logic       extSelect;
    logic       rcSelect;
    logic [1:0] rcRange;
    logic       crystalPinsFree;
    logic       wdtOscForTimeout;
  } csst_clk_sel_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } csst_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } csst_apb_rsp_type;

endpackage

/* csst_top.sv */
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module csst_top #(
  parameter logic [23:0] DELAY_SHORT_CYC = 24'(csst_pkg::DELAY_SHORT_CYC),
  parameter logic [23:0] DELAY_LONG_CYC  = 24'(csst_pkg::DELAY_LONG_CYC)
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       clkEn,
  // apb slave
  input  wire csst_pkg::csst_apb_req_type apbReq,
  output var  csst_pkg::csst_apb_rsp_type apbRsp,
  // fuse and signature pins
  input  wire logic [3:0]                 clockSourceSelectFuses,
  input  wire logic [1:0]                 startupTimeFuses,
  input  wire logic [7:0]                 calibrationByte,
  // power control, same clock
  input  wire logic                       sleepRequest,
  input  wire logic                       wakeRequest,
  // clock control outputs
  output var  csst_pkg::csst_clk_sel_type clkSel,
  output var  logic [7:0]                 trimValue,
  output var  logic                       internalReset,
  output var  logic                       systemClockEnable
);

  // reset view of the select outputs: the shipped 1 MHz rc code, no function call in the reset branch
  localparam csst_pkg::csst_clk_sel_type CLK_SEL_RESET = '{
    extSelect:        1'b0,
    rcSelect:         1'b1,
    rcRange:          csst_pkg::RC_RANGE_1MHZ,
    crystalPinsFree:  1'b1,
    wdtOscForTimeout: 1'b1
  };

  function automatic csst_pkg::csst_clk_sel_type decodeSource(input logic [3:0] code);
    csst_pkg::csst_clk_sel_type sel;
    sel = '0;
    sel.wdtOscForTimeout = 1'b1;
    unique case (code)
      csst_pkg::SRC_EXT: sel.extSelect = 1'b1;
      csst_pkg::SRC_RC1: sel.rcRange = csst_pkg::RC_RANGE_1MHZ;
      csst_pkg::SRC_RC2: sel.rcRange = csst_pkg::RC_RANGE_2MHZ;
      csst_pkg::SRC_RC4: sel.rcRange = csst_pkg::RC_RANGE_4MHZ;
      csst_pkg::SRC_RC8: sel.rcRange = csst_pkg::RC_RANGE_8MHZ;
      default: sel.rcRange = csst_pkg::RC_RANGE_1MHZ;
    endcase
    sel.rcSelect = (code >= csst_pkg::SRC_RC1) && (code <= csst_pkg::SRC_RC8);
    sel.crystalPinsFree = sel.rcSelect;
    return sel;
  endfunction

  function automatic logic [3:0] delayClass(input logic [1:0] code);
    // one-hot-ish: bit0 none, bit1 short, bit2 long, bit3 reserved
    logic [3:0] cls;
    cls = 4'h0;
    unique case (code)
      csst_pkg::SUT_NONE:     cls = 4'h1;
      csst_pkg::SUT_SHORT:    cls = 4'h2;
      csst_pkg::SUT_LONG:     cls = 4'h4;
      csst_pkg::SUT_RESERVED: cls = 4'h8;
    endcase
    return cls;
  endfunction

  // guaranteed min/max percent of nominal, piecewise through the three anchor points
  function automatic logic [31:0] trimRange(input logic [7:0] trim);
    logic [15:0] minPct;
    logic [15:0] maxPct;
    minPct = 16'h0000;
    maxPct = 16'h0000;
    if (trim <= csst_pkg::TRIM_MID)
    begin
      minPct = csst_pkg::PCT_LOW_MIN + 16'((16'(trim) * csst_pkg::PCT_STEP) / csst_pkg::TRIM_LO_SPAN);
    end
    else
    begin
      minPct = csst_pkg::PCT_MID_MIN
             + 16'((16'(trim - csst_pkg::TRIM_MID) * csst_pkg::PCT_STEP) / csst_pkg::TRIM_HI_SPAN);
    end
    maxPct = 16'(minPct << 1);
    return {maxPct, minPct};
  endfunction

  // pin synchronisers
  logic [3:0] srcMeta_reg;
  logic [3:0] srcSync_reg;
  logic [1:0] sutMeta_reg;
  logic [1:0] sutSync_reg;
  logic [7:0] calMeta_reg;
  logic [7:0] calSync_reg;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      srcMeta_reg <= csst_pkg::SRC_FUSE_DEFAULT;
      srcSync_reg <= csst_pkg::SRC_FUSE_DEFAULT;
      sutMeta_reg <= csst_pkg::SUT_FUSE_DEFAULT;
      sutSync_reg <= csst_pkg::SUT_FUSE_DEFAULT;
      calMeta_reg <= csst_pkg::TRIM_RESET;
      calSync_reg <= csst_pkg::TRIM_RESET;
    end
    else if (clkEn)
    begin
      srcMeta_reg <= clockSourceSelectFuses;
      srcSync_reg <= srcMeta_reg;
      sutMeta_reg <= startupTimeFuses;
      sutSync_reg <= sutMeta_reg;
      calMeta_reg <= calibrationByte;
      calSync_reg <= calMeta_reg;
    end
  end

  // multi-bit pin words are taken only after two equal synced samples,
  // so a word caught mid-change never reaches the fuse shadow or the trim
  logic [3:0] srcHold_reg;
  logic [1:0] sutHold_reg;
  logic [7:0] calHold_reg;
  logic       srcSteady;
  logic       sutSteady;
  logic       calSteady;

  assign srcSteady = (srcHold_reg == srcSync_reg);
  assign sutSteady = (sutHold_reg == sutSync_reg);
  assign calSteady = (calHold_reg == calSync_reg);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      srcHold_reg <= csst_pkg::SRC_FUSE_DEFAULT;
      sutHold_reg <= csst_pkg::SUT_FUSE_DEFAULT;
      calHold_reg <= csst_pkg::TRIM_RESET;
    end
    else if (clkEn)
    begin
      srcHold_reg <= srcSync_reg;
      sutHold_reg <= sutSync_reg;
      calHold_reg <= calSync_reg;
    end
  end

  // sequencer state
  csst_pkg::csst_state_type         state_reg;
  csst_pkg::csst_state_type         state_next;
  logic                             fromReset_reg;
  logic [csst_pkg::STARTUP_W-1:0]   startupCnt_reg;
  logic [csst_pkg::DELAY_W-1:0]     delayCnt_reg;
  logic [3:0]                       fuseSrc_reg;
  logic [1:0]                       fuseSut_reg;
  logic [3:0]                       sutClass;
  logic [csst_pkg::DELAY_W-1:0]     delayTarget;
  logic                             startupDone;
  logic                             delayDone;
  logic                             resetPhase;

  assign sutClass    = delayClass(fuseSut_reg);
  // reserved code falls back to the longest delay, the safe side
  assign delayTarget = sutClass[1] ? DELAY_SHORT_CYC : DELAY_LONG_CYC;
  assign startupDone = (startupCnt_reg == csst_pkg::STARTUP_CK - 3'h1);
  assign delayDone   = (delayCnt_reg == delayTarget - 24'h000001);
  assign resetPhase  = fromReset_reg && (state_reg != csst_pkg::ST_RUN);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      csst_pkg::ST_STARTUP:
      begin
        if (startupDone)
        begin
          if (fromReset_reg && !sutClass[0])
          begin
            state_next = csst_pkg::ST_DELAY;
          end
          else
          begin
            state_next = csst_pkg::ST_RUN;
          end
        end
      end
      csst_pkg::ST_DELAY:
      begin
        if (delayDone)
        begin
          state_next = csst_pkg::ST_RUN;
        end
      end
      csst_pkg::ST_RUN:
      begin
        if (sleepRequest)
        begin
          state_next = csst_pkg::ST_SLEEP;
        end
      end
      csst_pkg::ST_SLEEP:
      begin
        if (wakeRequest)
        begin
          state_next = csst_pkg::ST_STARTUP;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg     <= csst_pkg::ST_STARTUP;
      fromReset_reg <= 1'b1;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      if (state_next == csst_pkg::ST_RUN)
      begin
        fromReset_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      startupCnt_reg <= '0;
      delayCnt_reg   <= '0;
    end
    else if (clkEn)
    begin
      startupCnt_reg <= (state_reg == csst_pkg::ST_STARTUP && !startupDone)
                        ? startupCnt_reg + 3'h1 : '0;
      delayCnt_reg   <= (state_reg == csst_pkg::ST_DELAY && !delayDone)
                        ? delayCnt_reg + 24'h000001 : '0;
    end
  end

  // fuses are latched only while coming out of reset; frozen during run and sleep
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fuseSrc_reg <= csst_pkg::SRC_FUSE_DEFAULT;
      fuseSut_reg <= csst_pkg::SUT_FUSE_DEFAULT;
    end
    else if (clkEn && fromReset_reg && state_reg == csst_pkg::ST_STARTUP)
    begin
      if (srcSteady)
      begin
        fuseSrc_reg <= srcSync_reg;
      end
      if (sutSteady)
      begin
        fuseSut_reg <= sutSync_reg;
      end
    end
  end

  // outputs of the sequencer
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      clkSel            <= CLK_SEL_RESET;
      internalReset     <= 1'b1;
      systemClockEnable <= 1'b0;
    end
    else if (clkEn)
    begin
      clkSel            <= decodeSource(fuseSrc_reg);
      internalReset     <= fromReset_reg && (state_next != csst_pkg::ST_RUN);
      systemClockEnable <= (state_next == csst_pkg::ST_RUN) || (state_next == csst_pkg::ST_DELAY);
    end
  end

  // apb slave, one wait state
  logic        apbAccess;
  logic        apbDone;
  logic        trimWrite;
  logic [31:0] status;
  logic [31:0] readData;
  logic        readErr;
  csst_pkg::csst_clk_sel_type fuseSel;

  assign apbAccess = apbReq.psel && apbReq.penable;
  assign apbDone   = apbAccess && apbRsp.pready;
  assign trimWrite = apbDone && apbReq.pwrite && (apbReq.paddr == csst_pkg::ADDR_TRIM);
  assign fuseSel   = decodeSource(fuseSrc_reg);

  always_comb
  begin
    status = 32'h00000000;
    status[csst_pkg::ST_SRC_LSB +: 4]   = fuseSrc_reg;
    status[csst_pkg::ST_SUT_LSB +: 2]   = fuseSut_reg;
    status[csst_pkg::ST_STATE_LSB +: 2] = state_reg;
    status[csst_pkg::ST_INTRST_BIT]     = internalReset;
    status[csst_pkg::ST_SYSCLK_BIT]     = systemClockEnable;
    status[csst_pkg::ST_BADSRC_BIT]     = !fuseSel.extSelect && !fuseSel.rcSelect;
    status[csst_pkg::ST_BADSUT_BIT]     = sutClass[3];
  end

  always_comb
  begin
    readData = 32'h00000000;
    readErr  = 1'b0;
    unique case (apbReq.paddr)
      csst_pkg::ADDR_TRIM:   readData = {24'h000000, trimValue};
      csst_pkg::ADDR_STATUS: readData = status;
      csst_pkg::ADDR_CALIB:  readData = {24'h000000, calSync_reg};
      csst_pkg::ADDR_RANGE:  readData = trimRange(trimValue);
      default:               readErr  = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      apbRsp <= '0;
    end
    else if (clkEn)
    begin
      apbRsp.pready  <= apbAccess && !apbRsp.pready;
      apbRsp.pslverr <= apbAccess && !apbRsp.pready && readErr;
      apbRsp.prdata  <= (apbAccess && !apbRsp.pready && !apbReq.pwrite) ? readData : 32'h00000000;
    end
  end

  // trim: hardware reload during the reset phase wins over any software write
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      trimValue <= csst_pkg::TRIM_RESET;
    end
    else if (clkEn)
    begin
      if (resetPhase)
      begin
        if (calSteady)
        begin
          trimValue <= calSync_reg;
        end
      end
      else if (trimWrite)
      begin
        trimValue <= apbReq.pwdata[7:0];
      end
    end
  end

endmodule // csst_top
`default_nettype wire

/* csst_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module csst_far_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // wanted programming
  input  wire logic [3:0] progSrc,
  input  wire logic [1:0] progSut,
  input  wire logic [7:0] progCal,
  // fuse and signature lines
  output var  logic [3:0] srcFuse,
  output var  logic [1:0] sutFuse,
  output var  logic [7:0] calByte
);
  // lines only move under reset, so the device never sees a running change
  // no option fuse or timer oscillator clock is driven at all
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      srcFuse <= progSrc;
      sutFuse <= progSut;
      calByte <= progCal;
    end
  end
endmodule // csst_far_model
`default_nettype wire

/* csst_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module csst_asserts #(
  parameter logic [23:0] DELAY_SHORT_CYC = 24'h000014,
  parameter logic [23:0] DELAY_LONG_CYC  = 24'h000028
) (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       sys_rst,
  input wire logic                       clkEn,
  // apb
  input wire csst_pkg::csst_apb_req_type apbReq,
  input wire csst_pkg::csst_apb_rsp_type apbRsp,
  // fuses and power
  input wire logic [3:0]                 clockSourceSelectFuses,
  input wire logic [1:0]                 startupTimeFuses,
  input wire logic [7:0]                 calibrationByte,
  input wire logic                       sleepRequest,
  input wire logic                       wakeRequest,
  // outputs
  input wire csst_pkg::csst_clk_sel_type clkSel,
  input wire logic [7:0]                 trimValue,
  input wire logic                       internalReset,
  input wire logic                       systemClockEnable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic        run;
  logic        asleep;
  logic [23:0] dlyCnt;
  assign run = systemClockEnable && !internalReset;
  // edges with the system clock on while internal reset is still held
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dlyCnt <= 24'h000000;
    end
    else if (clkEn && systemClockEnable && internalReset)
    begin
      dlyCnt <= dlyCnt + 24'h000001;
    end
  end
  // mirrors a sleep taken in run until the wake request that ends it
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      asleep <= 1'b0;
    end
    else if (clkEn && run && sleepRequest)
    begin
      asleep <= 1'b1;
    end
    else if (clkEn && asleep && wakeRequest)
    begin
      asleep <= 1'b0;
    end
  end
  property p_rel; $fell(sys_rst) |-> internalReset && !systemClockEnable && trimValue == 8'h00; endproperty
  a_rel: assert property (p_rel) else $error("bad state at reset release");
  property p_src; run |-> clkSel.extSelect == (clockSourceSelectFuses == 4'h0)
    && clkSel.rcSelect == (clockSourceSelectFuses inside {[4'h1:4'h4]}); endproperty
  a_src: assert property (p_src) else $error("source decode wrong");
  property p_rng; run && clkSel.rcSelect |-> clkSel.rcRange == 2'(clockSourceSelectFuses - 4'h1); endproperty
  a_rng: assert property (p_rng) else $error("rc range wrong");
  property p_pins; run |-> clkSel.crystalPinsFree == clkSel.rcSelect && clkSel.wdtOscForTimeout; endproperty
  a_pins: assert property (p_pins) else $error("pin release or watchdog mark wrong");
  property p_ack; apbReq.psel && apbReq.penable && !apbRsp.pready && clkEn |=> apbRsp.pready ##1 !apbRsp.pready;
  endproperty
  a_ack: assert property (p_ack) else $error("apb answer timing wrong");
  property p_err; apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without ready or with data");
  property p_trim; apbRsp.pready && apbReq.pwrite && apbReq.paddr == csst_pkg::ADDR_TRIM && !internalReset
    && clkEn |=> trimValue == $past(apbReq.pwdata[7:0]); endproperty
  a_trim: assert property (p_trim) else $error("trim write lost");
  property p_cal; $rose(systemClockEnable) && $past(internalReset) |-> trimValue == calibrationByte; endproperty
  a_cal: assert property (p_cal) else $error("calibration not loaded");
  property p_slp; run && sleepRequest && clkEn |=> !systemClockEnable; endproperty
  a_slp: assert property (p_slp) else $error("sleep not taken");
  property p_wrst; !internalReset |=> !internalReset; endproperty
  a_wrst: assert property (p_wrst) else $error("reset came back without reset");
  property p_dly; $fell(internalReset) |-> dlyCnt == ((startupTimeFuses == 2'h0) ? 24'h000000
    : (startupTimeFuses == 2'h1) ? DELAY_SHORT_CYC : DELAY_LONG_CYC); endproperty
  a_dly: assert property (p_dly) else $error("reset delay length wrong");
  property p_wake; asleep && wakeRequest && clkEn |=> !systemClockEnable [*6] ##1 systemClockEnable; endproperty
  a_wake: assert property (p_wake) else $error("wake start-up length wrong");
endmodule // csst_asserts
`default_nettype wire

/* clock_source_select_and_trim_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_source_select_and_trim_tb_top;
  // short delays keep the run brief
  localparam logic [23:0] SHORT = 24'h000014;
  localparam logic [23:0] LONG  = 24'h000028;
  logic                       mclk, sys_rst, clkEn, sleepRequest, wakeRequest, internalReset, systemClockEnable, e;
  logic [3:0]                 srcFuse, progSrc;
  logic [1:0]                 sutFuse, progSut;
  logic [7:0]                 calByte, progCal, trimValue;
  logic [31:0]                q;
  csst_pkg::csst_apb_req_type apbReq;
  csst_pkg::csst_apb_rsp_type apbRsp;
  csst_pkg::csst_clk_sel_type clkSel;
  int                         mismatches, checked, n, i;
  logic [3:0]                 cs [6] = '{4'h1, 4'h0, 4'h2, 4'h3, 4'h4, 4'h5};
  logic [1:0]                 ct [6] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h2, 2'h1};
  logic [7:0]                 cc [6] = '{8'h5a, 8'h3c, 8'hc3, 8'h81, 8'h7e, 8'h11};
  logic [7:0]                 tv [3] = '{8'h00, 8'h7f, 8'hff};
  logic [31:0]                rv [3] = '{32'h00640032, 32'h0096004b, 32'h00c80064};
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  csst_top #(.DELAY_SHORT_CYC(SHORT), .DELAY_LONG_CYC(LONG)) csst_top_inst (.mclk(mclk), .sys_rst(sys_rst),
    .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp), .clockSourceSelectFuses(srcFuse),
    .startupTimeFuses(sutFuse), .calibrationByte(calByte), .sleepRequest(sleepRequest),
    .wakeRequest(wakeRequest), .clkSel(clkSel), .trimValue(trimValue), .internalReset(internalReset),
    .systemClockEnable(systemClockEnable));
  csst_far_model csst_far_model_inst (.mclk(mclk), .sys_rst(sys_rst), .progSrc(progSrc), .progSut(progSut),
    .progCal(progCal), .srcFuse(srcFuse), .sutFuse(sutFuse), .calByte(calByte));
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task report_and_stop;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // pready and data are read as sampled at the rising edge at which the slave acts
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (apbRsp.pready !== 1'b1 && k < 40);
    if (apbRsp.pready !== 1'b1)
      chk("pready", 32'h1, 32'h0);
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
  endtask
  task boot(input logic [3:0] s, input logic [1:0] t, input logic [7:0] c);
    int g;
    progSrc <= s;
    progSut <= t;
    progCal <= c;
    sys_rst <= 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    n = 0;
    while (systemClockEnable !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    g = 0;
    while (internalReset !== 1'b0 && g < 200)
    begin
      @(negedge mclk);
      g++;
    end
    chk("delay", (t == 2'h0) ? 32'h0 : (t == 2'h1) ? 32'(SHORT) : 32'(LONG), g);
    chk("trim", 32'(c), 32'(trimValue));
    @(posedge mclk);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    apbReq = '0;
    sleepRequest = 1'b0;
    wakeRequest = 1'b0;
    progSrc = csst_pkg::SRC_FUSE_DEFAULT;
    progSut = csst_pkg::SUT_FUSE_DEFAULT;
    progCal = 8'h5a;
    mismatches = 0;
    checked = 0;
    @(posedge mclk);
    boot(csst_pkg::SRC_FUSE_DEFAULT, csst_pkg::SUT_FUSE_DEFAULT, 8'h5a);
    apb(csst_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk("shipped", 32'h00000b21, q);
    for (i = 0; i < 3; i++)
    begin
      // no nonvolatile write runs in this bench, so any trim value is allowed
      apb(csst_pkg::ADDR_TRIM, 1'b1, {24'hffffff, tv[i]});
      apb(csst_pkg::ADDR_TRIM, 1'b0, 32'h0);
      chk("trimreg", {24'h0, tv[i]}, q);
      apb(csst_pkg::ADDR_RANGE, 1'b0, 32'h0);
      chk("range", rv[i], q);
    end
    apb(12'h010, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapdata", 32'h0, q);
    apb(csst_pkg::ADDR_CALIB, 1'b1, 32'hff);
    apb(csst_pkg::ADDR_CALIB, 1'b0, 32'h0);
    chk("calreg", 32'h5a, q);
    $display("registers test done");
    sleepRequest <= 1'b1;
    @(posedge mclk);
    sleepRequest <= 1'b0;
    @(negedge mclk);
    chk("sleep", 32'h0, 32'(systemClockEnable));
    @(posedge mclk);
    wakeRequest <= 1'b1;
    @(posedge mclk);
    wakeRequest <= 1'b0;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (systemClockEnable !== 1'b1 && n < 50);
    chk("wake", 32'h7, n);
    chk("wakerst", 32'h0, 32'(internalReset));
    // a sleep request while the clock enable is low must be lost
    @(posedge mclk);
    clkEn <= 1'b0;
    sleepRequest <= 1'b1;
    repeat (3) @(posedge mclk);
    sleepRequest <= 1'b0;
    clkEn <= 1'b1;
    chk("freeze", 32'h1, 32'(systemClockEnable));
    $display("sleep test done");
    // the first pass also proves that reset reloads over the trims written above
    for (i = 0; i < 6; i++)
    begin
      boot(cs[i], ct[i], cc[i]);
      apb(csst_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("status", {18'h0, ct[i] == 2'h3, cs[i] > 4'h4, 4'hb, 2'h0, ct[i], cs[i]}, q);
      chk("clksel", {26'h0, cs[i] == 4'h0, cs[i] inside {[4'h1:4'h4]},
        (cs[i] inside {[4'h1:4'h4]}) ? 2'(cs[i] - 4'h1) : 2'h0, cs[i] inside {[4'h1:4'h4]}, 1'b1},
        32'(clkSel));
      $display("fuse test %0d done", i);
    end
    report_and_stop;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop;
  end
endmodule // clock_source_select_and_trim_tb_top
bind csst_top csst_asserts #(.DELAY_SHORT_CYC(DELAY_SHORT_CYC), .DELAY_LONG_CYC(DELAY_LONG_CYC)) csst_asserts_inst (
  .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
  .clockSourceSelectFuses(clockSourceSelectFuses), .startupTimeFuses(startupTimeFuses),
  .calibrationByte(calibrationByte), .sleepRequest(sleepRequest), .wakeRequest(wakeRequest), .clkSel(clkSel),
  .trimValue(trimValue), .internalReset(internalReset), .systemClockEnable(systemClockEnable));
`default_nettype wire
